// [rtl/backoff_ctrl.sv]
// Cache controller end: lock strap capture, abort pulses, address wiring.
// Assumes the link interface, one bus clock, deadlock inputs on that clock.
//
// Contract
// [R1] Capture lock select while reset asserted
// [R2] Captured high selects address lock mechanism
// [R3] Captured low selects cache lock mode
// [R4] System holds lock select constant after reset
// [R5] Abort only on modified hit deadlock
// [R6] Each abort lasts exactly one clock
// [R7] Two identical aborts, asserted together
// [R8] Processor abandons cycle, floats its bus
// [R9] SRAM drops cycle state, memory side continues
// [R10] Strobed mode SRAM inputs glitch free
// [R11] Parity slices: enables high, parity low
// [R12] Address bits map per cache size
// [R13] Aborts idle from reset until deadlock
`timescale 1ns/100ps
`include "backoff_params.svh"

module backoff_ctrl
  import backoff_pkg::*;
(
  input  logic                     clk_i,                  // Bus clock
  input  logic                     rst_b_i,                // Sync reset, low
  input  logic                     ce_i,                   // Clock enable
  input  logic                     cache_size_2mb_i,       // Size strap pin
  input  logic                     inquire_hit_modified_i, // Inquire hit M line
  input  logic                     outstanding_cycle_i,    // CPU cycle pending
  input  logic                     final_ready_blocked_i,  // Last ready cannot come
  output logic                     address_lock_mode_o,    // Address lock in use
  output logic                     cache_lock_mode_o,      // Cache lock in use
  output logic                     cache_2mb_mode_o,       // 2 Mbyte wiring in use
  output logic                     abort_issued_o,         // Abort pulse copy
  output logic [`CSL_W-1:0]        chunk_select_o,         // Chunk select
  output logic [`CFA_W-1:0]        configurable_address_bits_o,
  output logic [`SET_W-1:0]        set_addr_o,             // Set index
  output logic [`TAG_W-1:0]        tag_addr_o,             // Tag
  backoff_link_if.ctrl             link
);

  // ------------------------------------------------------------
  // Address mapping function
  // ------------------------------------------------------------
  // Packs {csl, cfa, set, tag} from processor address bits
  localparam int MAP_W = `CSL_W + `CFA_W + `SET_W + `TAG_W;

  function automatic logic [MAP_W-1:0] map_addr(
    input logic [`ADDR_HI:`ADDR_LO] a,
    input cache_size_t              sz
  );
    logic [`CSL_W-1:0] csl;
    logic [`CFA_W-1:0] cfa;
    logic [`SET_W-1:0] set;
    logic [`TAG_W-1:0] tag;
    csl = a[4:3];
    if (sz == SIZE_2MB) begin
      // 2 Mbyte wiring
      cfa = {a[6], a[5], 1'b0};
      set = {a[19], a[18], a[17:7]};
      tag = {a[31], a[30:20]};
    end else begin
      // 1 Mbyte wiring
      cfa = {a[5], 1'b0, a[31]};
      set = {a[18], a[17:7], a[6]};
      tag = {a[30:20], a[19]};
    end
    map_addr = {csl, cfa, set, tag};
  endfunction : map_addr

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic                     lock_meta_reg;   // Lock strap, stage 1
  logic                     lock_sync_reg;   // Lock strap, stage 2
  logic                     size_meta_reg;   // Size strap, stage 1
  logic                     size_sync_reg;   // Size strap, stage 2
  logic [`ADDR_HI:`ADDR_LO] addr_meta_reg;   // Address, stage 1
  logic [`ADDR_HI:`ADDR_LO] addr_sync_reg;   // Address, stage 2

  // Two flops per pin; left unreset so they track pins during reset
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      lock_meta_reg <= link.lock_protocol_select;
      lock_sync_reg <= lock_meta_reg;
      size_meta_reg <= cache_size_2mb_i;
      size_sync_reg <= size_meta_reg;
      addr_meta_reg <= link.cpu_addr;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Configuration capture
  // ------------------------------------------------------------
  lock_mode_t  lock_mode_reg;   // Captured lock protocol
  cache_size_t size_reg;        // Captured cache size

  // [R1] sample during reset
  // Strap values follow the synchronised pins while reset is low
  // and freeze at release; later pin activity is ignored.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (!rst_b_i) begin
        lock_mode_reg <= lock_mode_t'(lock_sync_reg);
        size_reg      <= cache_size_t'(size_sync_reg);
      end
    end
  end

  // ------------------------------------------------------------
  // Lock mode and cache size outputs
  // ------------------------------------------------------------
  logic address_lock_reg;  // Address lock flag
  logic cache_lock_reg;    // Cache lock flag
  logic size_2mb_reg;      // Size flag

  // Mode flags decoded from the captured strap
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      // [R2] high means address lock
      address_lock_reg <= (lock_mode_reg == LOCK_ADDRESS);
      // [R3] low means cache lock
      cache_lock_reg   <= (lock_mode_reg == LOCK_CACHE);
      size_2mb_reg     <= (size_reg == SIZE_2MB);
    end
  end

  // ------------------------------------------------------------
  // Deadlock detection and abort sequencer
  // ------------------------------------------------------------
  abort_state_t state_reg;     // Sequencer state
  abort_state_t state_next;    // Next state
  logic         abort_n_reg;   // Processor abort, low active
  logic         sram_n_reg;    // SRAM abort, low active
  logic         issued_reg;    // Pulse copy for the user side
  wire          deadlock_w;    // Deadlock present
  wire          abort_now_w;   // Next clock is the abort clock

  // [R5] modified hit with blocked cycle
  assign deadlock_w  = inquire_hit_modified_i & outstanding_cycle_i & final_ready_blocked_i;
  assign abort_now_w = (state_next == ST_ABORT);

  // Next state: one abort per deadlock occurrence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // Wait for a deadlock
      ST_IDLE: begin
        if (deadlock_w) begin
          state_next = ST_ABORT;
        end
      end
      // [R6] leave after one clock
      ST_ABORT: begin
        state_next = deadlock_w ? ST_HOLD : ST_IDLE;
      end
      // Hold off until the deadlock has cleared
      ST_HOLD: begin
        if (!deadlock_w) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State and abort flops
  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_b_i) begin
      // [R13] aborts idle from reset
      state_reg   <= ST_IDLE;
      abort_n_reg <= `ABORT_IDLE_N;
      sram_n_reg  <= `ABORT_IDLE_N;
      issued_reg  <= 1'b0;
    end else if (ce_i) begin
      state_reg   <= state_next;
      // [R7] both aborts together
      abort_n_reg <= ~abort_now_w;
      sram_n_reg  <= ~abort_now_w;
      issued_reg  <= abort_now_w;
    end
  end

  // ------------------------------------------------------------
  // Address wiring
  // ------------------------------------------------------------
  wire  [MAP_W-1:0]  map_w;     // Mapped address fields
  logic [MAP_W-1:0]  map_reg;   // Registered fields

  // [R12] size dependent bit map
  assign map_w = map_addr(addr_sync_reg, size_reg);

  // Register the mapped address so outputs come from flops
  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_b_i) begin
      map_reg <= '0;
    end else if (ce_i) begin
      map_reg <= map_w;
    end
  end

  // ------------------------------------------------------------
  // Output wiring
  // ------------------------------------------------------------
  assign address_lock_mode_o         = address_lock_reg;
  assign cache_lock_mode_o           = cache_lock_reg;
  assign cache_2mb_mode_o            = size_2mb_reg;
  assign abort_issued_o              = issued_reg;
  assign link.cpu_abort_request_n    = abort_n_reg;
  assign link.sram_abort_request_n   = sram_n_reg;
  assign chunk_select_o              = map_reg[MAP_W-1 -: `CSL_W];
  assign configurable_address_bits_o = map_reg[`CFA_W+`SET_W+`TAG_W-1 -: `CFA_W];
  assign set_addr_o                  = map_reg[`SET_W+`TAG_W-1 -: `SET_W];
  assign tag_addr_o                  = map_reg[`TAG_W-1:0];

endmodule : backoff_ctrl

// [inc/backoff_params.svh]
// Constants for the back-off, lock-select and address-wiring ends.
// Assumes inclusion by bare name from the package and both design files.
`ifndef BACKOFF_PARAMS_SVH
`define BACKOFF_PARAMS_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define ADDR_HI            31
`define ADDR_LO            3
`define SET_W              13
`define TAG_W              12
`define CFA_W              3
`define CSL_W              2
`define SLICE_DATA_W       8
`define NIBBLE_W           4
`define PARITY_SLICES      2
`define STROBE_W           5

// ------------------------------------------------------------
// Strobe vector bit positions
// ------------------------------------------------------------
`define STB_INPUT          0
`define STB_OUTPUT         1
`define STB_END_OF_CYCLE   2
`define STB_SELECT         3
`define STB_ZERO_BUFFER    4

// ------------------------------------------------------------
// Timing and reset values
// ------------------------------------------------------------
`define CLK_PERIOD_NS      100
`define ABORT_PULSE_CLKS   1
`define ABORT_IDLE_N       1'b1
`define STROBE_IDLE_N      5'h1F

`endif

// [inc/backoff_pkg.sv]
// Types shared by the controller end and the processor/SRAM end.
// Assumes the constants header sits on the include path.
`include "backoff_params.svh"

package backoff_pkg;

  // ------------------------------------------------------------
  // Abort pulse sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,  // No deadlock seen
    ST_ABORT = 2'b01,  // Abort outputs low this clock
    ST_HOLD  = 2'b10   // Wait for deadlock to clear
  } abort_state_t;

  // Lock protocol chosen at reset
  typedef enum logic {
    LOCK_CACHE   = 1'b0,  // Cache lock mode
    LOCK_ADDRESS = 1'b1   // Address lock mechanism
  } lock_mode_t;

  // Cache size chosen at reset
  typedef enum logic {
    SIZE_1MB = 1'b0,
    SIZE_2MB = 1'b1
  } cache_size_t;

endpackage : backoff_pkg

// [inc/backoff_link_if.sv]
// Wires between the cache controller and the processor/SRAM end.
// Assumes both ends run on the same processor bus clock.
`timescale 1ns/100ps
`include "backoff_params.svh"

interface backoff_link_if;
  logic                                    lock_protocol_select;   // Lock strap pin
  logic                                    cpu_abort_request_n;    // Abort to processor
  logic                                    sram_abort_request_n;   // Abort to SRAM slices
  logic [`ADDR_HI:`ADDR_LO]                cpu_addr;               // Processor address
  logic                                    cpu_addr_oe;            // Address driven
  logic [`PARITY_SLICES-1:0][`SLICE_DATA_W-1:0] slice_cpu_data;    // Parity slice data
  logic                                    slice_cpu_data_oe;      // Slice data driven
  logic                                    mem_input_strobe_n;     // Strobed mode inputs
  logic                                    mem_output_strobe_n;
  logic                                    mem_end_of_cycle_n;
  logic                                    mem_slice_select_n;
  logic                                    mem_zero_buffer_transfer_n;

  // Controller end
  modport ctrl (
    input  lock_protocol_select,
    input  cpu_addr,
    input  cpu_addr_oe,
    output cpu_abort_request_n,
    output sram_abort_request_n
  );

  // Processor and SRAM end
  modport cpu (
    output lock_protocol_select,
    output cpu_addr,
    output cpu_addr_oe,
    output slice_cpu_data,
    output slice_cpu_data_oe,
    output mem_input_strobe_n,
    output mem_output_strobe_n,
    output mem_end_of_cycle_n,
    output mem_slice_select_n,
    output mem_zero_buffer_transfer_n,
    input  cpu_abort_request_n,
    input  sram_abort_request_n
  );
endinterface : backoff_link_if

// [rtl/backoff_cpu_end.sv]
// Processor and SRAM slice end: strap drive, abort reaction, slice wiring.
// Assumes the link interface and the controller on the same bus clock.
`timescale 1ns/100ps
`include "backoff_params.svh"

module backoff_cpu_end
  import backoff_pkg::*;
(
  input  logic                          clk_i,              // Bus clock
  input  logic                          rst_b_i,            // Sync reset, low
  input  logic                          ce_i,               // Clock enable
  input  logic                          lock_strap_i,       // Wanted lock strap
  input  logic                          cycle_start_i,      // New CPU cycle
  input  logic [`ADDR_HI:`ADDR_LO]      cpu_addr_i,         // Cycle address
  input  logic [7:0]                    cpu_byte_enables_n_i,
  input  logic [7:0]                    cpu_data_parity_i,
  input  logic                          strobed_mode_i,     // SRAM strobed mode
  input  logic [`STROBE_W-1:0]          strobe_req_n_i,     // Raw strobe requests
  output logic                          cycle_active_o,     // Cycle in progress
  output logic                          bus_released_o,     // Bus floated
  output logic                          sram_state_cleared_o, // Slice state dropped
  backoff_link_if.cpu                   link
);

  // ------------------------------------------------------------
  // Lock strap drive
  // ------------------------------------------------------------
  logic strap_reg;  // Strap level held on the pin

  // [R4] strap constant after reset
  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_b_i) begin
      strap_reg <= lock_strap_i;
    end
  end

  // ------------------------------------------------------------
  // Abort synchronisers
  // ------------------------------------------------------------
  logic cpu_meta_reg;   // Processor abort, stage 1
  logic cpu_sync_reg;   // Processor abort, stage 2
  logic sram_meta_reg;  // SRAM abort, stage 1
  logic sram_sync_reg;  // SRAM abort, stage 2

  // Pins pass two flops; reset to idle high
  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_b_i) begin
      cpu_meta_reg  <= `ABORT_IDLE_N;
      cpu_sync_reg  <= `ABORT_IDLE_N;
      sram_meta_reg <= `ABORT_IDLE_N;
      sram_sync_reg <= `ABORT_IDLE_N;
    end else if (ce_i) begin
      cpu_meta_reg  <= link.cpu_abort_request_n;
      cpu_sync_reg  <= cpu_meta_reg;
      sram_meta_reg <= link.sram_abort_request_n;
      sram_sync_reg <= sram_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Cycle tracking and abort reaction
  // ------------------------------------------------------------
  logic                     active_reg;    // Cycle in progress
  logic                     released_reg;  // Bus floated by abort
  logic                     cleared_reg;   // Slice state dropped pulse
  logic [`ADDR_HI:`ADDR_LO] addr_reg;      // Driven address
  wire                      cpu_abort_w;   // Processor abort seen
  wire                      sram_abort_w;  // SRAM abort seen

  assign cpu_abort_w  = ~cpu_sync_reg;
  assign sram_abort_w = ~sram_sync_reg;

  // Abort wins over a cycle start in the same clock
  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_b_i) begin
      active_reg   <= 1'b0;
      released_reg <= 1'b0;
      cleared_reg  <= 1'b0;
      addr_reg     <= '0;
    end else if (ce_i) begin
      // [R8] abandon cycle, float bus
      if (cpu_abort_w) begin
        active_reg   <= 1'b0;
        released_reg <= 1'b1;
      end else if (cycle_start_i) begin
        active_reg   <= 1'b1;
        released_reg <= 1'b0;
        addr_reg     <= cpu_addr_i;
      end
      // [R9] slices drop cycle state
      cleared_reg <= sram_abort_w;
    end
  end

  // ------------------------------------------------------------
  // Parity slice data
  // ------------------------------------------------------------
  logic [`PARITY_SLICES-1:0][`SLICE_DATA_W-1:0] slice_reg;  // Slice lanes

  // [R11] enables high nibble, parity low
  for (genvar s = 0; s < `PARITY_SLICES; s++) begin : g_slice
    always_ff @(posedge clk_i) begin
      if (ce_i && !rst_b_i) begin
        slice_reg[s] <= '0;
      end else if (ce_i) begin
        slice_reg[s] <= {cpu_byte_enables_n_i[s*`NIBBLE_W +: `NIBBLE_W],
                         cpu_data_parity_i[s*`NIBBLE_W +: `NIBBLE_W]};
      end
    end
  end

  // ------------------------------------------------------------
  // Strobed mode SRAM inputs
  // ------------------------------------------------------------
  logic [`STROBE_W-1:0] strobe_reg;  // Registered strobes

  // [R10] flops keep strobes glitch free
  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_b_i) begin
      strobe_reg <= `STROBE_IDLE_N;
    end else if (ce_i) begin
      strobe_reg <= strobed_mode_i ? strobe_req_n_i : `STROBE_IDLE_N;
    end
  end

  // ------------------------------------------------------------
  // Output wiring
  // ------------------------------------------------------------
  assign link.lock_protocol_select       = strap_reg;
  assign link.cpu_addr                   = addr_reg;
  assign link.cpu_addr_oe                = active_reg;
  assign link.slice_cpu_data             = slice_reg;
  assign link.slice_cpu_data_oe          = active_reg;
  assign link.mem_input_strobe_n         = strobe_reg[`STB_INPUT];
  assign link.mem_output_strobe_n        = strobe_reg[`STB_OUTPUT];
  assign link.mem_end_of_cycle_n         = strobe_reg[`STB_END_OF_CYCLE];
  assign link.mem_slice_select_n         = strobe_reg[`STB_SELECT];
  assign link.mem_zero_buffer_transfer_n = strobe_reg[`STB_ZERO_BUFFER];
  assign cycle_active_o                  = active_reg;
  assign bus_released_o                  = released_reg;
  assign sram_state_cleared_o            = cleared_reg;

endmodule : backoff_cpu_end

// [sim/backoff_link_monitor.sv]
// Concurrent checks on the link between the controller and processor ends.
// Assumes link signals are wired in as plain inputs on one bus clock.
`timescale 1ns/100ps

module backoff_link_monitor (
  input logic clk_i,                      // Bus clock
  input logic rst_b_i,                    // Sync reset, low
  input logic lock_protocol_select,       // Lock strap
  input logic cpu_abort_request_n,        // Abort to processor
  input logic sram_abort_request_n,       // Abort to slices
  input logic cpu_addr_oe,                // Address driven
  input logic slice_cpu_data_oe,          // Slice data driven
  input logic mem_input_strobe_n,
  input logic mem_output_strobe_n,
  input logic mem_end_of_cycle_n,
  input logic mem_slice_select_n,
  input logic mem_zero_buffer_transfer_n
);
  // ----------------------------------------
  // Clocking and strobe grouping
  // ----------------------------------------
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire [4:0] stbs_n = {mem_zero_buffer_transfer_n, mem_slice_select_n,
                       mem_end_of_cycle_n, mem_output_strobe_n, mem_input_strobe_n};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_abort_pair_same: assert property (
    cpu_abort_request_n == sram_abort_request_n) else $error("abort lines differ");
  a_abort_one_clk: assert property (
    !cpu_abort_request_n |=> cpu_abort_request_n) else $error("abort longer than 1 clk");
  a_reset_abort_idle: assert property (
    disable iff (1'b0) !rst_b_i |=> cpu_abort_request_n && sram_abort_request_n)
    else $error("abort active in reset");
  a_lock_sel_hold: assert property (
    $past(rst_b_i) |-> $stable(lock_protocol_select)) else $error("lock select moved");
  a_bus_float_after: assert property (
    !cpu_abort_request_n |-> ##3 !cpu_addr_oe) else $error("bus not floated");
  a_slice_state_drop: assert property (
    !sram_abort_request_n |-> ##3 !slice_cpu_data_oe) else $error("slice state kept");
  a_slice_oe_pair: assert property (
    slice_cpu_data_oe == cpu_addr_oe) else $error("slice enable mismatch");
  a_strobe_reset_idle: assert property (
    disable iff (1'b0) !rst_b_i |=> stbs_n == 5'h1F) else $error("strobes not idle");

  // ----------------------------------------
  // Coverage of main scenarios
  // ----------------------------------------
  c_abort_pulse: cover property ($fell(cpu_abort_request_n));
  c_cache_lock: cover property (!lock_protocol_select);
  c_slice_drive: cover property ($rose(slice_cpu_data_oe));
endmodule : backoff_link_monitor

// [sim/cache_ctrl_backoff_lock_cfg_tb.sv]
// Self-checking bench joining the controller end and the processor end.
// Assumes the package, the interface and both design files are compiled first.
`timescale 1ns/100ps
`include "backoff_params.svh"

module cache_ctrl_backoff_lock_cfg_tb;
  // ----------------------------------------
  // Stimulus rows and signals
  // ----------------------------------------
  typedef struct packed {
    logic [31:3] a;    // Cycle address
    logic [7:0]  be;   // Byte enables, low
    logic [7:0]  par;  // Data parity
    logic [4:0]  stb;  // Raw strobes, low
    logic [2:0]  dl;   // Deadlock inputs
  } row_t;
  row_t rows [8] = '{
    '{29'h1FFFFFFF, 8'hA5, 8'h3C, 5'h0A, 3'h0},
    '{29'h00000000, 8'h0F, 8'hF0, 5'h15, 3'h1},
    '{29'h15555555, 8'h5A, 8'hC3, 5'h1F, 3'h2},
    '{29'h0AAAAAAA, 8'hFF, 8'h00, 5'h00, 3'h3},
    '{29'h10000001, 8'h81, 8'h18, 5'h11, 3'h4},
    '{29'h0FFFFFFE, 8'h7E, 8'hE7, 5'h0E, 3'h5},
    '{29'h12345678, 8'h12, 8'h34, 5'h05, 3'h6},
    '{29'h0ABCDEF0, 8'hC0, 8'h03, 5'h1B, 3'h7}};
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic strap = 1'b1;
  logic size2 = 1'b0;
  logic [2:0] dl = 3'h0;
  logic cyc_start = 1'b0;
  logic [31:3] addr = '0;
  logic [7:0] be_n = 8'hFF;
  logic [7:0] par = 8'h00;
  logic smode = 1'b0;
  logic [4:0] stb_n = 5'h1F;
  logic addr_lock, cache_lock, mode2, abort_issued, cyc_act, released, cleared;
  logic [1:0] csl;
  logic [2:0] cfa;
  logic [12:0] set_a;
  logic [11:0] tag_a;
  int fail_count = 0;
  int n_tests = 0;
  int n_pulse = 0;
  int n_clr = 0;
  backoff_link_if backoff_link_if_i ();
  wire [4:0] stbs = {backoff_link_if_i.mem_zero_buffer_transfer_n,
    backoff_link_if_i.mem_slice_select_n, backoff_link_if_i.mem_end_of_cycle_n,
    backoff_link_if_i.mem_output_strobe_n, backoff_link_if_i.mem_input_strobe_n};

  // ----------------------------------------
  // Design ends and monitor
  // ----------------------------------------
  backoff_ctrl backoff_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .cache_size_2mb_i(size2), .inquire_hit_modified_i(dl[2]), .outstanding_cycle_i(dl[1]),
    .final_ready_blocked_i(dl[0]), .address_lock_mode_o(addr_lock),
    .cache_lock_mode_o(cache_lock), .cache_2mb_mode_o(mode2), .abort_issued_o(abort_issued),
    .chunk_select_o(csl), .configurable_address_bits_o(cfa), .set_addr_o(set_a),
    .tag_addr_o(tag_a), .link(backoff_link_if_i));
  backoff_cpu_end backoff_cpu_end_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .lock_strap_i(strap), .cycle_start_i(cyc_start), .cpu_addr_i(addr),
    .cpu_byte_enables_n_i(be_n), .cpu_data_parity_i(par), .strobed_mode_i(smode),
    .strobe_req_n_i(stb_n), .cycle_active_o(cyc_act), .bus_released_o(released),
    .sram_state_cleared_o(cleared), .link(backoff_link_if_i));
  backoff_link_monitor backoff_link_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .lock_protocol_select(backoff_link_if_i.lock_protocol_select),
    .cpu_abort_request_n(backoff_link_if_i.cpu_abort_request_n),
    .sram_abort_request_n(backoff_link_if_i.sram_abort_request_n),
    .cpu_addr_oe(backoff_link_if_i.cpu_addr_oe),
    .slice_cpu_data_oe(backoff_link_if_i.slice_cpu_data_oe),
    .mem_input_strobe_n(stbs[0]), .mem_output_strobe_n(stbs[1]),
    .mem_end_of_cycle_n(stbs[2]), .mem_slice_select_n(stbs[3]),
    .mem_zero_buffer_transfer_n(stbs[4]));

  // ----------------------------------------
  // Clock, pulse counters, watchdog
  // ----------------------------------------
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // Count pulse cycles away from the launching edge
  always @(negedge clk_i) begin
    if (abort_issued === 1'b1) n_pulse++;
    if (cleared === 1'b1) n_clr++;
  end
  initial begin
    #400000;
    fail_count++;
    summarize();
  end

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec
  // Expected chunk, configurable, set and tag fields for each cache size
  function automatic logic [29:0] map_exp(input logic [31:3] a, input logic mb2);
    if (mb2) begin
      map_exp = {a[4:3], a[6], a[5], 1'b0, a[19:7], a[31:20]};
    end else begin
      map_exp = {a[4:3], a[5], 1'b0, a[31], a[18:6], a[30:19]};
    end
  endfunction : map_exp
  task automatic do_reset(input logic lk, input logic mb2);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    strap <= lk;
    size2 <= mb2;
    dl <= 3'h0;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit(backoff_link_if_i.cpu_abort_request_n, 1'b1);
    chk_bit(abort_issued, 1'b0);
    chk_vec({27'h0, stbs}, 32'h1F);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit(backoff_link_if_i.lock_protocol_select, lk);
    chk_bit(addr_lock, lk);
    chk_bit(cache_lock, !lk);
    chk_bit(mode2, mb2);
  endtask : do_reset
  task automatic apply_row(input row_t r, input logic mb2, input logic sm);
    @(posedge clk_i);
    addr <= r.a;
    be_n <= r.be;
    par <= r.par;
    stb_n <= r.stb;
    smode <= sm;
    cyc_start <= 1'b1;
    @(posedge clk_i);
    cyc_start <= 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk_vec({2'h0, csl, cfa, set_a, tag_a}, {2'h0, map_exp(r.a, mb2)});
    chk_vec({16'h0, backoff_link_if_i.slice_cpu_data},
            {16'h0, r.be[7:4], r.par[7:4], r.be[3:0], r.par[3:0]});
    chk_vec({27'h0, stbs}, {27'h0, sm ? r.stb : 5'h1F});
    @(posedge clk_i);
    n_pulse = 0;
    n_clr = 0;
    dl <= r.dl;
    @(posedge clk_i);
    dl <= 3'h0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk_vec(n_pulse, {31'h0, r.dl == 3'h7});
    chk_vec(n_clr, {31'h0, r.dl == 3'h7});
    chk_bit(released, r.dl == 3'h7);
    chk_bit(cyc_act, r.dl != 3'h7);
  endtask : apply_row
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset(1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      apply_row(rows[i], 1'b0, i[0]);
    end
    // Mid-run reset into cache lock and the larger wiring
    do_reset(1'b0, 1'b1);
    apply_row(rows[6], 1'b1, 1'b1);
    // Held deadlock gives one pulse, a fresh one after a gap gives another
    @(posedge clk_i);
    n_pulse = 0;
    dl <= 3'h7;
    repeat (5) @(posedge clk_i);
    dl <= 3'h0;
    @(posedge clk_i);
    dl <= 3'h7;
    @(posedge clk_i);
    dl <= 3'h0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk_vec(n_pulse, 32'h2);
    summarize();
  end
endmodule : cache_ctrl_backoff_lock_cfg_tb
